// ==== include/cfgsr_pkg.sv ====
// Purpose: Constants and types shared by the configuration save/restore block
// Assumes: Object address is {index[15:0], subindex[7:0]}
// Notes: Category mask bit order is comm, app, customer, drive, tuning
package cfgsr_pkg;
    localparam int ADDR_W = 24;
    localparam int CAT_W = 5;
    localparam int SUB_N = 6;

    localparam logic [15:0] IDX_STORE = 16'h1010;
    localparam logic [15:0] IDX_RESTORE = 16'h1011;
    localparam logic [15:0] IDX_MARKER = 16'h1020;
    localparam logic [15:0] IDX_REBOOT = 16'h2800;

    localparam logic [7:0] SUB_ALL = 8'h01;
    localparam logic [7:0] SUB_COMM = 8'h02;
    localparam logic [7:0] SUB_TUNE = 8'h06;
    localparam logic [7:0] SUB_LAST = 8'h06;
    localparam logic [7:0] SUB_DATE = 8'h01;
    localparam logic [7:0] SUB_TIME = 8'h02;
    localparam logic [7:0] SUB_BOOT = 8'h01;

    localparam logic [31:0] MAGIC_SAVE = 32'h65766173;
    localparam logic [31:0] MAGIC_LOAD = 32'h64616f6c;
    localparam logic [31:0] MAGIC_BOOT = 32'h746f6f62;
    localparam logic [31:0] SAVE_DONE_WORD = 32'h00000001;
    localparam logic [31:0] MARKER_RST = 32'h00000000;
    localparam logic [31:0] STORE_RST = 32'h00000000;

    localparam logic [4:0] CAT_SAVE_ALL = 5'h1f;
    localparam logic [4:0] CAT_DISC_ALL = 5'h0f;
    localparam logic [4:0] CAT_COMM = 5'h01;
    localparam logic [4:0] CAT_TUNE = 5'h10;

    typedef enum logic [1:0] {
        CFGSR_IDLE = 2'b00,
        CFGSR_BUSY = 2'b01,
        CFGSR_DONE = 2'b10
    } cfgsr_seq_t;

    // Subindex 1 picks the caller's notion of all; 2..6 pick one category
    function automatic logic [4:0] cfgsr_sub_cat(input logic [7:0] sub, input logic [4:0] all);
        logic [4:0] m;
        m = 5'h00;
        case (sub)
            8'h01: m = all;
            8'h02: m = 5'h01;
            8'h03: m = 5'h02;
            8'h04: m = 5'h04;
            8'h05: m = 5'h08;
            8'h06: m = 5'h10;
            default: m = 5'h00;
        endcase
        return m;
    endfunction : cfgsr_sub_cat
endpackage : cfgsr_pkg

// ==== verilog/cfgsr_save_seq.sv ====
// Purpose: Runs one save of a category mask against the nonvolatile store
// Assumes: nv_done_i is a one-cycle pulse from logic on the same clock
// Notes: A start while busy is ignored; the caller checks busy_o first
`timescale 1ns/10ps
`default_nettype none
module cfgsr_save_seq (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic start_i,
    input wire logic [4:0] mask_i,
    input wire logic nv_done_i,
    output logic busy_o,
    output logic [4:0] nv_save_o,
    output logic done_o
);
    cfgsr_pkg::cfgsr_seq_t state_r;
    logic [4:0] mask_r;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_r <= cfgsr_pkg::CFGSR_IDLE;
        end else begin
            case (state_r)
                cfgsr_pkg::CFGSR_IDLE: if (start_i) state_r <= cfgsr_pkg::CFGSR_BUSY;
                cfgsr_pkg::CFGSR_BUSY: if (nv_done_i) state_r <= cfgsr_pkg::CFGSR_DONE;
                cfgsr_pkg::CFGSR_DONE: state_r <= cfgsr_pkg::CFGSR_IDLE;
                default: state_r <= cfgsr_pkg::CFGSR_IDLE;
            endcase
        end
    end

    // Request stays up until the store answers, so a slow store simply stretches it
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            mask_r <= 5'h00;
        end else if (state_r == cfgsr_pkg::CFGSR_IDLE && start_i) begin
            mask_r <= mask_i;
        end else if (state_r == cfgsr_pkg::CFGSR_BUSY && nv_done_i) begin
            mask_r <= 5'h00;
        end
    end

    assign nv_save_o = mask_r;
    assign busy_o = (state_r != cfgsr_pkg::CFGSR_IDLE);
    assign done_o = (state_r == cfgsr_pkg::CFGSR_DONE);

    property p_seq_hold;
        @(posedge clk_i) disable iff (reset_i)
        (state_r == cfgsr_pkg::CFGSR_BUSY && !nv_done_i) |=> $stable(nv_save_o) && busy_o;
    endproperty
    a_seq_hold: assert property (p_seq_hold) else $error("save request dropped early"); // [R11]

    property p_seq_done;
        @(posedge clk_i) disable iff (reset_i)
        (state_r == cfgsr_pkg::CFGSR_BUSY && nv_done_i) |=> done_o ##1 !busy_o;
    endproperty
    a_seq_done: assert property (p_seq_done) else $error("save completion not signalled"); // [R11]
endmodule : cfgsr_save_seq
`default_nettype wire

// ==== verilog/cfgsr_top.sv ====
// Purpose: Save, discard, restart and modification-marker control of the configuration store
// Assumes: Object address is {index, subindex}; one strobe at a time; same-clock partners
// Notes: Active values other than the marker live outside; this block sequences the store and the restart and holds the marker
// What this block and its master do
// R1: Load word on a category discard subindex discards that category's stored objects.
// R2: Discard on subindex 1 restores factory settings for all categories except tuning.
// R3: Discard leaves active values alone; they take effect only after a restart.
// R4: Boot word written to reboot subindex 1 restarts the controller.
// R5: Tuning objects are discarded only via the tuning subindex.
// R6: Marker date and time accept writes and are stored by a save-all.
// R7: Writes to savable objects clear the marker, except save-all and marker writes.
// R8: Master configures, writes the marker, then issues save-all.
// R9: After restart the master treats a zero marker as a modified configuration.
// R10: A marker differing from the expected one means unexpected saved values.
// R11: A finished save overwrites its save subindex with the value one.
// R12: Discard subindices 2..5 map comm, app, customer, drive; 6 tuning; 1 all.
`timescale 1ns/10ps
`default_nettype none
module cfgsr_top (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [23:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic savable_wr_i,
    input wire logic nv_done_i,
    output logic [4:0] nv_save_o,
    output logic [4:0] nv_discard_o,
    output logic [4:0] discard_pending_o,
    output logic save_busy_o,
    output logic restart_o
);
    logic [15:0] idx;
    logic [7:0] sub;
    logic sub_ok;
    logic wr_store;
    logic wr_restore;
    logic wr_marker;
    logic wr_reboot;
    logic save_start;
    logic save_fin;
    logic disc_go;
    logic marker_clr;
    logic [2:0] wr_slot;
    logic [2:0] save_slot_r;
    logic [7:0] save_sub_r;
    logic [31:0] store_val_r [0:5];
    logic [31:0] date_r;
    logic [31:0] time_r;
    logic [31:0] snap_date_r;
    logic [31:0] snap_time_r;
    logic [31:0] kept_date_r;
    logic [31:0] kept_time_r;
    logic [4:0] pending_r;
    logic [4:0] discard_r;
    logic restart_r;
    logic [31:0] rdata_r;
    logic [31:0] done_val;

    assign idx = addr_i[23:8];
    assign sub = addr_i[7:0];
    assign sub_ok = (sub >= cfgsr_pkg::SUB_ALL) && (sub <= cfgsr_pkg::SUB_LAST);
    assign wr_slot = 3'(sub - cfgsr_pkg::SUB_ALL);
    assign wr_store = wr_i && idx == cfgsr_pkg::IDX_STORE && sub_ok;
    assign wr_restore = wr_i && idx == cfgsr_pkg::IDX_RESTORE && sub_ok;
    assign wr_marker = wr_i && idx == cfgsr_pkg::IDX_MARKER;
    assign wr_reboot = wr_i && idx == cfgsr_pkg::IDX_REBOOT && sub == cfgsr_pkg::SUB_BOOT;
    assign save_start = wr_store && wdata_i == cfgsr_pkg::MAGIC_SAVE && !save_busy_o;
    assign disc_go = wr_restore && wdata_i == cfgsr_pkg::MAGIC_LOAD;
    // Save-all and the marker itself leave the marker intact
    assign marker_clr = savable_wr_i || (wr_store && sub != cfgsr_pkg::SUB_ALL); // [R7]

    cfgsr_save_seq u_seq (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .start_i(save_start),
        .mask_i(cfgsr_pkg::cfgsr_sub_cat(sub, cfgsr_pkg::CAT_SAVE_ALL)),
        .nv_done_i(nv_done_i),
        .busy_o(save_busy_o),
        .nv_save_o(nv_save_o),
        .done_o(save_fin)
    );

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            save_slot_r <= 3'h0;
            save_sub_r <= 8'h00;
        end else if (save_start) begin
            save_slot_r <= wr_slot;
            save_sub_r <= sub;
        end
    end

    // Completion overwrite wins over a software write in the same cycle
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < cfgsr_pkg::SUB_N; i++) begin
                store_val_r[i] <= cfgsr_pkg::STORE_RST;
            end
        end else begin
            if (wr_store) begin
                store_val_r[wr_slot] <= wdata_i;
            end
            if (save_fin) begin
                store_val_r[save_slot_r] <= cfgsr_pkg::SAVE_DONE_WORD; // [R11]
            end
        end
    end

    // Active marker; a restart reloads it from the stored copy
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            date_r <= cfgsr_pkg::MARKER_RST;
            time_r <= cfgsr_pkg::MARKER_RST;
        end else if (restart_r) begin
            date_r <= kept_date_r; // [R9]
            time_r <= kept_time_r;
        end else if (marker_clr) begin
            date_r <= cfgsr_pkg::MARKER_RST; // [R7]
            time_r <= cfgsr_pkg::MARKER_RST;
        end else if (wr_marker && sub == cfgsr_pkg::SUB_DATE) begin
            date_r <= wdata_i; // [R6]
        end else if (wr_marker && sub == cfgsr_pkg::SUB_TIME) begin
            time_r <= wdata_i; // [R6]
        end
    end

    // Snapshot at start so marker writes during a long save do not leak in
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            snap_date_r <= cfgsr_pkg::MARKER_RST;
            snap_time_r <= cfgsr_pkg::MARKER_RST;
        end else if (save_start && sub == cfgsr_pkg::SUB_ALL) begin
            snap_date_r <= date_r;
            snap_time_r <= time_r;
        end
    end

    // Stored marker belongs to the communication category
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            kept_date_r <= cfgsr_pkg::MARKER_RST;
            kept_time_r <= cfgsr_pkg::MARKER_RST;
        end else if (save_fin && save_sub_r == cfgsr_pkg::SUB_ALL) begin
            kept_date_r <= snap_date_r; // [R6]
            kept_time_r <= snap_time_r;
        end else if (disc_go && (cfgsr_pkg::cfgsr_sub_cat(sub, cfgsr_pkg::CAT_DISC_ALL)
                     & cfgsr_pkg::CAT_COMM) != 5'h00) begin
            kept_date_r <= cfgsr_pkg::MARKER_RST; // [R1]
            kept_time_r <= cfgsr_pkg::MARKER_RST;
        end
    end

    // Discard hits the store now; active values wait for the restart
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            discard_r <= 5'h00;
        end else if (disc_go) begin
            discard_r <= cfgsr_pkg::cfgsr_sub_cat(sub, cfgsr_pkg::CAT_DISC_ALL); // [R1] [R2] [R5] [R12]
        end else begin
            discard_r <= 5'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pending_r <= 5'h00;
        end else if (restart_r) begin
            // A discard landing in the restart cycle outlives that restart: the set wins
            pending_r <= disc_go ? cfgsr_pkg::cfgsr_sub_cat(sub, cfgsr_pkg::CAT_DISC_ALL)
                                 : 5'h00; // [R3]
        end else if (disc_go) begin
            pending_r <= pending_r | cfgsr_pkg::cfgsr_sub_cat(sub, cfgsr_pkg::CAT_DISC_ALL);
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            restart_r <= 1'b0;
        end else begin
            restart_r <= wr_reboot && wdata_i == cfgsr_pkg::MAGIC_BOOT; // [R4]
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_r <= 32'h00000000;
        end else if (rd_i) begin
            if (idx == cfgsr_pkg::IDX_STORE && sub_ok) begin
                rdata_r <= store_val_r[wr_slot];
            end else if (idx == cfgsr_pkg::IDX_RESTORE && sub_ok) begin
                rdata_r <= {27'h0000000, pending_r & cfgsr_pkg::cfgsr_sub_cat(sub, 5'h1f)};
            end else if (idx == cfgsr_pkg::IDX_MARKER && sub == cfgsr_pkg::SUB_DATE) begin
                rdata_r <= date_r;
            end else if (idx == cfgsr_pkg::IDX_MARKER && sub == cfgsr_pkg::SUB_TIME) begin
                rdata_r <= time_r;
            end else begin
                rdata_r <= 32'h00000000;
            end
        end else begin
            rdata_r <= 32'h00000000;
        end
    end

    assign rdata_o = rdata_r;
    assign nv_discard_o = discard_r;
    assign discard_pending_o = pending_r;
    assign restart_o = restart_r;
    assign done_val = store_val_r[save_slot_r];

    property p_disc_cat;
        @(posedge clk_i) disable iff (reset_i)
        (disc_go && sub == cfgsr_pkg::SUB_COMM) |=> nv_discard_o == 5'h01
            ##1 (nv_discard_o == 5'h00 || $past(disc_go));
    endproperty
    a_disc_cat: assert property (p_disc_cat) else $error("category discard wrong"); // [R1] [R12]

    property p_disc_all;
        @(posedge clk_i) disable iff (reset_i)
        (disc_go && sub == cfgsr_pkg::SUB_ALL) |=> nv_discard_o == 5'h0f;
    endproperty
    a_disc_all: assert property (p_disc_all) else $error("discard-all mask wrong"); // [R2]

    property p_tune_only;
        @(posedge clk_i) disable iff (reset_i)
        nv_discard_o[4] |-> $past(sub) == cfgsr_pkg::SUB_TUNE && $past(wr_i);
    endproperty
    a_tune_only: assert property (p_tune_only) else $error("tuning discarded by other subindex"); // [R5]

    property p_pend_hold;
        @(posedge clk_i) disable iff (reset_i)
        (pending_r != 5'h00 && !restart_r && !wr_marker && !marker_clr) |=> pending_r != 5'h00
            && $stable(date_r) && $stable(time_r);
    endproperty
    a_pend_hold: assert property (p_pend_hold) else $error("discard took effect before restart"); // [R3]

    property p_boot;
        @(posedge clk_i) disable iff (reset_i)
        (wr_reboot && wdata_i == cfgsr_pkg::MAGIC_BOOT) |=> restart_o
            ##1 (pending_r & ~nv_discard_o) == 5'h00;
    endproperty
    a_boot: assert property (p_boot) else $error("boot word did not restart"); // [R4]

    property p_keep;
        @(posedge clk_i) disable iff (reset_i)
        (save_fin && save_sub_r == cfgsr_pkg::SUB_ALL) |=> kept_date_r == $past(snap_date_r)
            && kept_time_r == $past(snap_time_r);
    endproperty
    a_keep: assert property (p_keep) else $error("save-all did not keep marker"); // [R6]

    property p_clr;
        @(posedge clk_i) disable iff (reset_i)
        (savable_wr_i && !restart_r) |=> date_r == 32'h0 && time_r == 32'h0;
    endproperty
    a_clr: assert property (p_clr) else $error("marker not cleared"); // [R7]

    property p_done;
        @(posedge clk_i) disable iff (reset_i)
        save_fin |=> done_val == cfgsr_pkg::SAVE_DONE_WORD;
    endproperty
    a_done: assert property (p_done) else $error("save subindex not set to one"); // [R11]

    c_save_all: cover property (@(posedge clk_i) save_fin && save_sub_r == cfgsr_pkg::SUB_ALL);
    c_disc_tune: cover property (@(posedge clk_i) nv_discard_o == 5'h10);
    c_restart: cover property (@(posedge clk_i) restart_o && pending_r != 5'h00);
endmodule : cfgsr_top
`default_nettype wire

// ==== dv/cfgsr_nv_model.sv ====
// Purpose: Behavioural nonvolatile store that answers the block's save requests
// Assumes: Same clock as the block; the save mask is held until the done pulse is taken
// Notes: Latency is set per test, so both a prompt and a slow store are exercised
`timescale 1ns/10ps
`default_nettype none
module cfgsr_nv_model (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [4:0] nv_save_i,
    input wire logic [3:0] delay_i,
    output logic nv_done_o
);
    logic [3:0] cnt_r;
    logic fired_r;
    logic done_r;

    // Rearm only after the mask drops, so a held mask is never answered twice
    always_ff @(posedge clk_i) begin
        done_r <= 1'b0;
        if (reset_i || nv_save_i == 5'h00) begin
            cnt_r <= 4'h0;
            fired_r <= 1'b0;
        end else if (!fired_r) begin
            if (cnt_r == delay_i) begin
                done_r <= 1'b1;
                fired_r <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
    assign nv_done_o = done_r;
endmodule : cfgsr_nv_model
`default_nettype wire

// ==== dv/cfgsr_top_tb.sv ====
// Purpose: Self-checking bench for the configuration save/restore block
// Assumes: Read data stand only in the cycle after the read strobe
// Notes: One task per scenario; the store model latency is varied between them
`timescale 1ns/10ps
`default_nettype none
module cfgsr_top_tb;
    logic clk_i;
    logic reset_i;
    logic [23:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
    logic [31:0] rdata;
    logic savable_wr;
    logic nv_done;
    logic [4:0] nv_save;
    logic [4:0] nv_discard;
    logic [4:0] pending;
    logic save_busy;
    logic restart;
    logic [3:0] nv_delay;
    logic [4:0] disc_exp [1:6] = '{5'h0f, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
    int n_mismatch;
    int num_checks;

    cfgsr_top cfgsr_top_i (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .savable_wr_i(savable_wr), .nv_done_i(nv_done),
        .nv_save_o(nv_save), .nv_discard_o(nv_discard), .discard_pending_o(pending),
        .save_busy_o(save_busy), .restart_o(restart));
    cfgsr_nv_model cfgsr_nv_model_i (.clk_i(clk_i), .reset_i(reset_i), .nv_save_i(nv_save),
        .delay_i(nv_delay), .nv_done_o(nv_done));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr_cmd(input logic [23:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
        #1;
    endtask : wr_cmd

    task automatic rd_chk(input logic [23:0] a, input logic [31:0] exp, input string what);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        chk(rdata, exp, what);
    endtask : rd_chk

    task automatic do_restart();
        wr_cmd(24'h280001, cfgsr_pkg::MAGIC_BOOT);
        chk({31'h0, restart}, 32'h1, "restart pulse");
        @(posedge clk_i);
        #1;
        chk({31'h0, restart}, 32'h0, "restart width");
        chk({27'h0, pending}, 32'h0, "pending after restart");
    endtask : do_restart

    task automatic do_save(input logic [7:0] sub, input logic [4:0] mask);
        wr_cmd({cfgsr_pkg::IDX_STORE, sub}, cfgsr_pkg::MAGIC_SAVE);
        chk({27'h0, nv_save}, {27'h0, mask}, "save mask");
        chk({31'h0, save_busy}, 32'h1, "busy");
        repeat (40) if (save_busy === 1'b1) begin
            @(posedge clk_i);
            #1;
        end
        chk({31'h0, save_busy}, 32'h0, "busy end");
        chk({27'h0, nv_save}, 32'h0, "mask dropped");
        rd_chk({cfgsr_pkg::IDX_STORE, sub}, cfgsr_pkg::SAVE_DONE_WORD, "done word");
    endtask : do_save

    task automatic t_reset();
        chk({17'h0, nv_save, nv_discard, pending}, 32'h0, "reset outputs");
        rd_chk(24'h102001, cfgsr_pkg::MARKER_RST, "reset date");
        rd_chk(24'h102002, cfgsr_pkg::MARKER_RST, "reset time");
        rd_chk(24'h101001, cfgsr_pkg::STORE_RST, "reset store");
        rd_chk(24'h300001, 32'h0, "unmapped read");
    endtask : t_reset

    // Master sequence: mark, save all, disturb, restart, verify the marker came back
    task automatic t_save_marker();
        nv_delay = 4'h7;
        wr_cmd(24'h102001, 32'h00c0ffee);
        wr_cmd(24'h102002, 32'h00123456);
        do_save(cfgsr_pkg::SUB_ALL, cfgsr_pkg::CAT_SAVE_ALL);
        rd_chk(24'h102001, 32'h00c0ffee, "marker kept by save-all");
        @(posedge clk_i);
        savable_wr <= 1'b1;
        @(posedge clk_i);
        savable_wr <= 1'b0;
        rd_chk(24'h102001, 32'h0, "marker cleared");
        do_restart();
        rd_chk(24'h102001, 32'h00c0ffee, "stored date");
        rd_chk(24'h102002, 32'h00123456, "stored time");
    endtask : t_save_marker

    task automatic t_discard_active();
        wr_cmd(24'h101102, cfgsr_pkg::MAGIC_LOAD);
        chk({27'h0, nv_discard}, 32'h01, "comm discard");
        rd_chk(24'h102001, 32'h00c0ffee, "active untouched");
        do_restart();
        rd_chk(24'h102001, 32'h0, "discarded marker after restart");
    endtask : t_discard_active

    task automatic t_discard_all();
        for (int s = 1; s <= 6; s++) begin
            wr_cmd({cfgsr_pkg::IDX_RESTORE, 8'(s)}, cfgsr_pkg::MAGIC_LOAD);
            chk({27'h0, nv_discard}, {27'h0, disc_exp[s]}, "discard mask");
            chk({27'h0, pending}, {27'h0, disc_exp[s]}, "pending");
            rd_chk({cfgsr_pkg::IDX_RESTORE, 8'(s)}, {27'h0, disc_exp[s]}, "pending read");
            do_restart();
        end
    endtask : t_discard_all

    task automatic t_refuse();
        wr_cmd(24'h101106, 32'h0);
        chk({27'h0, nv_discard}, 32'h0, "non-magic discard");
        wr_cmd(24'h280002, cfgsr_pkg::MAGIC_BOOT);
        chk({31'h0, restart}, 32'h0, "boot on wrong subindex");
        wr_cmd(24'h280001, cfgsr_pkg::MAGIC_LOAD);
        chk({31'h0, restart}, 32'h0, "wrong boot word");
    endtask : t_refuse

    task automatic t_cat_save();
        nv_delay = 4'h0;
        wr_cmd(24'h102001, 32'h00000abc);
        wr_cmd(24'h101003, 32'h00000005);
        rd_chk(24'h102001, 32'h0, "store sub write clears");
        wr_cmd(24'h102001, 32'h00000abc);
        wr_cmd(24'h101001, 32'h00000005);
        rd_chk(24'h102001, 32'h00000abc, "save-all sub exempt");
        do_save(cfgsr_pkg::SUB_TUNE, cfgsr_pkg::CAT_TUNE);
        rd_chk(24'h102001, 32'h0, "category save clears");
        // A save word while busy is stored but starts nothing
        nv_delay = 4'h7;
        wr_cmd(24'h101002, cfgsr_pkg::MAGIC_SAVE);
        wr_cmd(24'h101003, cfgsr_pkg::MAGIC_SAVE);
        chk({27'h0, nv_save}, 32'h01, "save while busy refused");
        repeat (40) if (save_busy === 1'b1) begin
            @(posedge clk_i);
            #1;
        end
        rd_chk(24'h101002, cfgsr_pkg::SAVE_DONE_WORD, "first save done");
        rd_chk(24'h101003, cfgsr_pkg::MAGIC_SAVE, "refused save keeps value");
    endtask : t_cat_save

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        reset_i = 1'b1;
        addr = 24'h0;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        savable_wr = 1'b0;
        nv_delay = 4'h7;
        n_mismatch = 0;
        num_checks = 0;
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        t_reset();
        t_save_marker();
        t_discard_active();
        t_discard_all();
        t_refuse();
        t_cat_save();
        end_of_test();
    end

    // The whole run needs about 150 cycles; twenty times that means a hang
    initial begin
        repeat (3000) @(posedge clk_i);
        n_mismatch++;
        $display("[ERR] %0t watchdog expired", $time);
        end_of_test();
    end
endmodule : cfgsr_top_tb
`default_nettype wire
